// file: verilog/dsrs_top.sv
// reset generation logic of the dual supply reset supervisor
// assumes comparator outputs and manual reset arrive asynchronously
`timescale 1ns/1ps
module dsrs_top
  import dsrs_pkg::*;
#(
  parameter logic [1:0]  OUT_MODE  = OUT_LOW_PP,
  parameter int unsigned HOLD_CNT  = HOLD_CYC,
  parameter int unsigned FLT_CNT   = GLITCH_CYC
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // monitor inputs, high while undervoltage
  input  wire logic i_uv_supply,
  input  wire logic i_uv_adjust,
  // manual reset, pulled high in the pad
  input  wire logic i_manual_reset_in_n,
  // reset pin
  output logic      o_reset_lvl,
  output logic      o_reset_oe,
  output logic      o_reset_active
);

  dsrs_regs_t r_q;
  dsrs_regs_t r_d;
  logic       cause;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.inp.sync_sup = {r_q.inp.sync_sup[0], i_uv_supply};
    r_d.inp.sync_adj = {r_q.inp.sync_adj[0], i_uv_adjust};
    r_d.inp.sync_mr  = {r_q.inp.sync_mr[0], i_manual_reset_in_n};
    // glitch filter: level must hold FLT_CNT cycles to change
    if (r_q.inp.sync_sup[1] == r_q.inp.uv_sup) begin
      r_d.inp.flt_sup = 5'h00;
    end else if (r_q.inp.flt_sup >= 5'(FLT_CNT - 1)) begin
      r_d.inp.flt_sup = 5'h00;
      r_d.inp.uv_sup  = r_q.inp.sync_sup[1];
    end else begin
      r_d.inp.flt_sup = r_q.inp.flt_sup + 5'h01;
    end
    if (r_q.inp.sync_adj[1] == r_q.inp.uv_adj) begin
      r_d.inp.flt_adj = 5'h00;
    end else if (r_q.inp.flt_adj >= 5'(FLT_CNT - 1)) begin
      r_d.inp.flt_adj = 5'h00;
      r_d.inp.uv_adj  = r_q.inp.sync_adj[1];
    end else begin
      r_d.inp.flt_adj = r_q.inp.flt_adj + 5'h01;
    end
    cause = r_q.inp.uv_sup | r_q.inp.uv_adj | ~r_q.inp.sync_mr[1];
    case (r_q.st)
      ST_ASSERT: begin
        r_d.rst_act = 1'b1;
        r_d.cnt     = '0;
        if (!cause) begin
          r_d.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        r_d.rst_act = 1'b1;
        if (cause) begin
          r_d.st  = ST_ASSERT;
          r_d.cnt = '0;
        end else if (r_q.cnt >= CNT_W'(HOLD_CNT - 1)) begin
          r_d.rst_act = 1'b0;
        end else begin
          r_d.cnt = r_q.cnt + 22'h000001;
        end
      end
      default: begin
        r_d.st      = ST_ASSERT;
        r_d.rst_act = 1'b1;
        r_d.cnt     = '0;
      end
    endcase
    if (cause) begin
      r_d.rst_act = 1'b1;
    end
    // pin drive per build option
    case (OUT_MODE)
      OUT_HIGH_PP: begin
        r_d.pin.lvl = r_d.rst_act;
        r_d.pin.oe  = 1'b1;
      end
      OUT_LOW_OD: begin
        r_d.pin.lvl = 1'b0;
        r_d.pin.oe  = r_d.rst_act;
      end
      default: begin
        r_d.pin.lvl = ~r_d.rst_act;
        r_d.pin.oe  = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_q.inp.sync_sup <= 2'h3;
      r_q.inp.sync_adj <= 2'h3;
      r_q.inp.sync_mr  <= 2'h3;
      r_q.inp.flt_sup  <= 5'h00;
      r_q.inp.flt_adj  <= 5'h00;
      r_q.inp.uv_sup   <= 1'b1;
      r_q.inp.uv_adj   <= 1'b1;
      r_q.st           <= ST_ASSERT;
      r_q.cnt          <= '0;
      r_q.rst_act      <= 1'b1;
      r_q.pin.lvl      <= (OUT_MODE == OUT_HIGH_PP) ? 1'b1 : 1'b0;
      r_q.pin.oe       <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_reset_lvl    = r_q.pin.lvl;
  assign o_reset_oe     = r_q.pin.oe;
  assign o_reset_active = r_q.rst_act;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [21:0] good_cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst || cause) begin
      good_cnt <= '0;
    end else if (good_cnt != 22'h3FFFFF) begin
      good_cnt <= good_cnt + 22'h000001;
    end
  end

  reset_at_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cause |=> o_reset_active)
    else $error("reset not asserted with cause present");
  manual_immediate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !r_q.inp.sync_mr[1] |=> o_reset_active)
    else $error("manual reset not honoured");
  hold_min_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!o_reset_active && $past(o_reset_active)) |-> good_cnt >= 22'(HOLD_CNT))
    else $error("reset released before hold time");
  hold_restart_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (r_q.st == ST_HOLD && cause) |=> (r_q.st == ST_ASSERT && r_q.cnt == 22'h0))
    else $error("hold not restarted");
  release_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (good_cnt > 22'(HOLD_CNT + 2)) |-> !o_reset_active)
    else $error("reset held too long");
  power_up_a: assert property (@(posedge i_clk)
    $fell(i_rst) |-> o_reset_active)
    else $error("reset not asserted after power up");
  pin_style_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_reset_oe == ((OUT_MODE == OUT_LOW_OD) ? o_reset_active : 1'b1)) &&
    (o_reset_lvl == ((OUT_MODE == OUT_HIGH_PP) ? o_reset_active :
                     ((OUT_MODE == OUT_LOW_OD) ? 1'b0 : !o_reset_active))))
    else $error("reset pin does not match build option");
  open_drain_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (OUT_MODE == OUT_LOW_OD) |-> (!o_reset_lvl && o_reset_oe == o_reset_active))
    else $error("open drain pin drives high");
  glitch_rej_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(r_q.inp.uv_sup) |-> $past(r_q.inp.sync_sup[1], 2))
    else $error("supply glitch passed filter");
  adj_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    r_q.inp.uv_adj |=> o_reset_active)
    else $error("adjustable undervoltage ignored");

  // ---------------------------------------------------------------
  // checks: input filter, sequencing
  // ---------------------------------------------------------------
  adj_filter_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(r_q.inp.uv_adj) |-> $past(r_q.inp.sync_adj[1], 2))
    else $error("adjustable glitch passed filter");
  sup_recover_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(r_q.inp.uv_sup) |-> !$past(r_q.inp.sync_sup[1], 2))
    else $error("supply recovery not filtered");
  adj_recover_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(r_q.inp.uv_adj) |-> !$past(r_q.inp.sync_adj[1], 2))
    else $error("adjustable recovery not filtered");
  assert_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (r_q.st == ST_ASSERT) |-> (r_q.cnt == 22'h0 && o_reset_active))
    else $error("hold count not cleared while asserted");
  release_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_reset_active) |-> ($past(r_q.st) == ST_HOLD && !$past(cause)))
    else $error("reset released outside hold");
  mr_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(r_q.inp.sync_mr[1]) |-> o_reset_active)
    else $error("reset released with manual reset");
  manual_latency_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_manual_reset_in_n) |-> ##3 o_reset_active)
    else $error("manual reset too slow");
  state_onehot_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $onehot(r_q.st))
    else $error("sequencer state not one hot");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  cov_release_c: cover property (@(posedge i_clk) $fell(o_reset_active));
  cov_manual_c:  cover property (@(posedge i_clk) $fell(r_q.inp.sync_mr[1]));
  cov_restart_c: cover property (@(posedge i_clk) r_q.st == ST_HOLD && cause);
  cov_adjust_c:  cover property (@(posedge i_clk) $rose(r_q.inp.uv_adj));
  cov_glitch_c:  cover property (@(posedge i_clk)
    (!r_q.inp.uv_sup && r_q.inp.flt_sup != 5'h00) ##1 (!r_q.inp.uv_sup && r_q.inp.flt_sup == 5'h00));

endmodule // dsrs_top

// file: verilog/dsrs_pkg.sv
// constants and types of the dual supply reset supervisor
// assumes a single 20 MHz clock domain
package dsrs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned HOLD_MS         = 140;
  localparam int unsigned HOLD_CYC        = (CLK_HZ / 1000) * HOLD_MS;
  localparam int unsigned GLITCH_CYC      = 16;
  localparam int unsigned CNT_W           = 22;

  // ---------------------------------------------------------------
  // output styles
  // ---------------------------------------------------------------
  localparam logic [1:0]  OUT_HIGH_PP     = 2'h0;
  localparam logic [1:0]  OUT_LOW_PP      = 2'h1;
  localparam logic [1:0]  OUT_LOW_OD      = 2'h2;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ASSERT = 2'b01,
    ST_HOLD   = 2'b10
  } dsrs_state_t;

  typedef struct packed {
    logic [1:0] sync_sup;
    logic [1:0] sync_adj;
    logic [1:0] sync_mr;
    logic [4:0] flt_sup;
    logic [4:0] flt_adj;
    logic       uv_sup;
    logic       uv_adj;
  } dsrs_in_t;

  typedef struct packed {
    logic lvl;
    logic oe;
  } dsrs_pin_t;

  typedef struct packed {
    dsrs_in_t    inp;
    dsrs_state_t st;
    logic [21:0] cnt;
    logic        rst_act;
    dsrs_pin_t   pin;
  } dsrs_regs_t;

endpackage : dsrs_pkg

// file: bench/dsrs_sink.sv
// far side model: the logic that takes the reset line
// assumes the board pull-up on the line, as open drain needs
`timescale 1ns/1ps
module dsrs_sink
  import dsrs_pkg::*;
#(
  parameter logic [1:0] MODE = OUT_LOW_OD
) (
  // reset pin
  input  wire logic i_lvl,
  input  wire logic i_oe,
  // resolved reset, high while held
  output logic      o_in_reset
);
  logic wire_lvl;
  assign wire_lvl   = i_oe ? i_lvl : 1'b1;
  assign o_in_reset = (MODE == OUT_HIGH_PP) ? wire_lvl : !wire_lvl;
endmodule // dsrs_sink

// file: bench/tb.sv
// testbench of the reset supervisor, open drain build
// assumes a short hold and filter count set here
`timescale 1ns/1ps
module tb;
  import dsrs_pkg::*;
  localparam int HC = 50;
  logic        i_clk, i_rst, uv_s, uv_a, mr_n, lvl, oe, act, seen;
  int          miscompares, checks, n, k;
  logic        exp_q[$];
  logic [31:0] lfsr = 32'h5F33F5C9;
  dsrs_top #(.OUT_MODE(OUT_LOW_OD), .HOLD_CNT(HC), .FLT_CNT(4)) DUT (.i_clk(i_clk),
    .i_rst(i_rst), .i_uv_supply(uv_s), .i_uv_adjust(uv_a), .i_manual_reset_in_n(mr_n),
    .o_reset_lvl(lvl), .o_reset_oe(oe), .o_reset_active(act));
  dsrs_sink sink (.i_lvl(lvl), .i_oe(oe), .o_in_reset(seen));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_act(input logic v, output int c);
    c = 0;
    while (act !== v) begin
      @(negedge i_clk);
      c++;
      if (c > 400) begin
        chk("timeout", 0, 1);
        complete_run();
      end
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge i_clk);
  endtask
  // watcher: every change of the line takes the oldest note
  always @(seen) begin
    if (!i_rst && $time > 0) begin
      if (exp_q.size() == 0) chk("unexpected line change", seen, ~seen);
      else chk("reset line", seen, exp_q.pop_front());
    end
  end
  initial begin
    i_rst = 1'b1; uv_s = 1'b0; uv_a = 1'b0; mr_n = 1'b1;
    cyc(8);
    chk("power up", {act, seen}, 2'b11);
    i_rst = 1'b0;
    exp_q.push_back(1'b0);
    wait_act(1'b0, n);
    chk("first hold", n >= HC, 1);
    chk("od released", oe, 1'b0);
    $display("test power_up done");
    exp_q.push_back(1'b1);
    mr_n = 1'b0;
    wait_act(1'b1, n);
    chk("manual latency", n <= 3, 1);
    cyc(5);
    mr_n = 1'b1;
    exp_q.push_back(1'b0);
    wait_act(1'b0, n);
    chk("manual hold", n >= HC, 1);
    $display("test manual done");
    for (k = 0; k < 2; k++) begin
      exp_q.push_back(1'b1);
      if (k == 0) uv_s = 1'b1;
      else uv_a = 1'b1;
      wait_act(1'b1, n);
      cyc(10);
      uv_s = 1'b0; uv_a = 1'b0;
      exp_q.push_back(1'b0);
      wait_act(1'b0, n);
      chk("monitor hold", n >= HC, 1);
    end
    $display("test monitors done");
    for (k = 0; k < 4; k++) begin
      lfsr = step(lfsr);
      uv_s = lfsr[2];
      uv_a = ~lfsr[2];
      cyc(1 + lfsr[1:0] % 3);
      uv_s = 1'b0;
      uv_a = 1'b0;
      cyc(20);
      chk("glitch ignored", act, 1'b0);
    end
    $display("test glitch done");
    exp_q.push_back(1'b1);
    mr_n = 1'b0;
    cyc(4);
    mr_n = 1'b1;
    cyc(20);
    mr_n = 1'b0;
    cyc(4);
    mr_n = 1'b1;
    exp_q.push_back(1'b0);
    wait_act(1'b0, n);
    chk("restart hold", n >= HC, 1);
    chk("notes left", exp_q.size(), 0);
    $display("test restart done");
    complete_run();
  end
endmodule // tb
